// *** dv/i2cm_bus_model.sv ***
// Behavioural slave and second master sharing the I2C lines
`timescale 1ns/1ps
`default_nettype none
module i2cm_bus_model (
  input  wire logic       scl,
  input  wire logic       sda,
  input  wire logic       grab,
  input  wire logic       foreign,
  input  var  int         stretch_ns,
  output logic            scl_oe,
  output logic            sda_oe,
  output logic [7:0]      rx_byte
);
  // ------------------------------------------------
  // Receiver, acknowledge, stretch and foreign frames
  // ------------------------------------------------
  logic       ack_drv = 1'b0;
  logic       scl_str = 1'b0;
  logic       scl_f   = 1'b0;
  logic       sda_f   = 1'b0;
  logic [7:0] sh      = 8'h00;
  int         nbit    = 0;
  // Wired-and of own pulls; grab forces lost arbitration
  assign sda_oe = ack_drv | grab | sda_f;
  assign scl_oe = scl_str | scl_f;
  initial rx_byte = 8'h00;
  // Start on the line restarts the bit count; settle first so a clock
  // falling in the same instant as the data is not taken for a start
  always @(negedge sda) begin
    #1;
    if (scl) nbit = 0;
  end
  // Shift in MSB first, byte ready after eight clocks
  always @(posedge scl) begin
    if (nbit < 8) sh = {sh[6:0], sda};
    nbit++;
    if (nbit == 8) rx_byte = sh;
  end
  // Acknowledge the ninth clock, optional clock stretch
  always @(negedge scl) begin
    ack_drv = (nbit == 8);
    if (stretch_ns > 0) begin
      scl_str = 1'b1;
      #(stretch_ns) scl_str = 1'b0;
    end
  end
  // Other master: start, one clock, stop at 400 ns period
  always @(posedge foreign) begin
    sda_f = 1'b1;
    #200 scl_f = 1'b1;
    #200 scl_f = 1'b0;
    #200 sda_f = 1'b0;
  end
endmodule : i2cm_bus_model
`default_nettype wire

// *** dv/i2cm_core_asserts.sv ***
// Concurrent checks on the ports of the I2C master tail block
`timescale 1ns/1ps
`default_nettype none
module i2cm_core_asserts
  import i2cm_pkg::*;
(
  input wire logic        SYS_CLK,
  input wire logic        RST_N,
  input wire logic        WB_CYC_I,
  input wire logic        WB_STB_I,
  input wire logic        WB_WE_I,
  input wire logic [3:0]  WB_ADR_I,
  input wire logic [3:0]  WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  input wire logic [31:0] WB_DAT_O,
  input wire logic        WB_ACK_O,
  input wire logic        SCL_I,
  input wire logic        SCL_O,
  input wire logic        SCL_OE,
  input wire logic        SDA_I,
  input wire logic        SDA_O,
  input wire logic        SDA_OE,
  input wire logic        SLEEP_I,
  input wire logic        WAKE_O
);
  // ------------------------------------------------
  // Bus handshake and pin sequencing
  // ------------------------------------------------
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);
  // New request on the register bus
  sequence s_req;
    WB_CYC_I && WB_STB_I && !WB_ACK_O;
  endsequence
  // Data pulled low while the clock is free
  sequence s_start_begin;
    $rose(SDA_OE) && !SCL_OE;
  endsequence
  a_ack_latency: assert property (s_req |=> WB_ACK_O)
    else $error("register bus ack late");
  a_ack_single: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack longer than one cycle");
  a_rdata_idle: assert property (!WB_ACK_O |-> WB_DAT_O == RD_ZERO)
    else $error("read data outside ack");
  a_pins_zero: assert property (!SCL_O && !SDA_O)
    else $error("open drain level not low");
  a_wake_sleep: assert property (!$past(SLEEP_I) |-> !WAKE_O)
    else $error("wake without sleep");
  a_clock_release: assert property ($fell(SCL_OE) |-> $past(SCL_OE, 2))
    else $error("clock low phase too short");
  a_data_release: assert property (
    $fell(SDA_OE) && !SCL_OE && SCL_I |-> !$past(SCL_OE, 2))
    else $error("data released before clock high period");
  a_start_order: assert property (s_start_begin |-> ##[1:1000] SCL_OE)
    else $error("start never drove clock low");
endmodule : i2cm_core_asserts

bind i2cm_core i2cm_core_asserts u_i2cm_core_asserts (
  .SYS_CLK(SYS_CLK), .RST_N(RST_N), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
  .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I),
  .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .SCL_I(SCL_I), .SCL_O(SCL_O),
  .SCL_OE(SCL_OE), .SDA_I(SDA_I), .SDA_O(SDA_O), .SDA_OE(SDA_OE),
  .SLEEP_I(SLEEP_I), .WAKE_O(WAKE_O));
`default_nettype wire

// *** dv/testbench.sv ***
// Self-checking bench for the I2C master tail block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin n_fail++; \
  $display("Error %s expected %0h seen %0h", nm, ex, got); end end
module testbench
  import i2cm_pkg::*;
;
  // ------------------------------------------------
  // Clock, pins, bus tasks and scenarios
  // ------------------------------------------------
  logic        SYS_CLK = 1'b0;
  logic        RST_N   = 1'b0;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, sleep = 1'b0;
  logic [3:0]  adr  = 4'h0;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] rdat, q;
  logic        ack, scl_o, scl_oe, sda_o, sda_oe, wake, m_scl_oe, m_sda_oe, last_bit;
  logic        grab = 1'b0, foreign = 1'b0;
  logic [7:0]  rx_byte, b, stat, rate;
  logic [7:0]  exp_q[$];
  int          stretch = 0, n_fail = 0, n_tests = 0, cyc_cnt = 0, hi_cnt = 0, seed;
  wire logic   scl = !(scl_oe | m_scl_oe);
  wire logic   sda = !(sda_oe | m_sda_oe);

  i2cm_core u_i2cm_core (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hF), .WB_DAT_I(wdat), .WB_DAT_O(rdat),
    .WB_ACK_O(ack), .SCL_I(scl), .SCL_O(scl_o), .SCL_OE(scl_oe), .SDA_I(sda),
    .SDA_O(sda_o), .SDA_OE(sda_oe), .SLEEP_I(sleep), .WAKE_O(wake));
  i2cm_bus_model u_i2cm_bus_model (.scl(scl), .sda(sda), .grab(grab), .foreign(foreign),
    .stretch_ns(stretch), .scl_oe(m_scl_oe), .sda_oe(m_sda_oe), .rx_byte(rx_byte));

  // Clock, line sampling, high-time count and timeout
  always #25 SYS_CLK = ~SYS_CLK;
  always @(posedge scl) last_bit = sda;
  always @(posedge SYS_CLK) begin
    cyc_cnt++;
    if (scl) hi_cnt++;
    if (cyc_cnt == 20000) begin
      n_fail++;
      close_out();
    end
  end

  task close_out();
    $display("Checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : close_out

  // Classic Wishbone single cycle, held until ack
  task wb(input logic w, input logic [3:0] a, input logic [7:0] d);
    @(posedge SYS_CLK);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= {24'h000000, d};
    do @(posedge SYS_CLK); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0; stb <= 1'b0;
  endtask : wb

  task wait_flag(input logic [7:0] m);
    int i;
    q = 32'h0000_0000;
    for (i = 0; i < 300 && (q[7:0] & m) == 8'h00; i++) wb(1'b0, ADR_STAT, 8'h00);
    stat = q[7:0];
  endtask : wait_flag

  task st();
    wb(1'b1, ADR_CTRL, 8'h31);
    wait_flag(8'h10);
    wb(1'b1, ADR_STAT, 8'h38);
  endtask : st

  task tx(input logic [7:0] d);
    exp_q.push_back(d);
    wb(1'b1, ADR_SHIFT, d);
    wait_flag(8'h10);
    b = exp_q.pop_front();
    `CHK("rx byte", b, rx_byte)
    wb(1'b1, ADR_STAT, 8'h38);
  endtask : tx

  initial begin
    seed = 32'h16446A82;
    repeat (4) @(posedge SYS_CLK);
    RST_N <= 1'b1;
    wb(1'b0, ADR_STAT, 8'h00); `CHK("status reset", 8'h00, q[7:0])
    wb(1'b0, ADR_RATE, 8'h00); `CHK("rate reset", RATE_RESET, q[7:0])
    wb(1'b0, 4'h2, 8'h00); `CHK("unmapped", RD_ZERO, q)
    rate = 8'h02 + 8'($unsigned($random(seed)) % 4);
    wb(1'b1, ADR_RATE, rate);
    wb(1'b0, ADR_RATE, 8'h00); `CHK("rate", rate, q[7:0])
    wb(1'b1, ADR_CTRL, 8'h21);
    st(); `CHK("start lines", 2'b00, {scl, sda})
    tx(8'($random(seed)));
    for (int k = 0; k < 2; k++) begin
      stretch = k * 300;
      hi_cnt = 0;
      wb(1'b1, ADR_CTRL, 8'h25 | 8'(k << 1));
      wb(1'b1, ADR_SHIFT, 8'h5A);
      wb(1'b0, ADR_STAT, 8'h00); `CHK("ack write_collision_flag", 8'h08, q[7:0] & 8'h09)
      wait_flag(8'h10); `CHK("ack bit", k[0], last_bit)
      `CHK("ack high", 1'b1, hi_cnt > rate && hi_cnt < rate + 8)
      wb(1'b0, ADR_CTRL, 8'h00); `CHK("ack enable", 1'b0, q[C_ACK_SEQUENCE_ENABLE])
      wb(1'b1, ADR_STAT, 8'h38);
    end
    stretch = 0;
    wb(1'b1, ADR_CTRL, 8'h29);
    wb(1'b1, ADR_SHIFT, 8'h33);
    wait_flag(8'h10); `CHK("stop status", 8'h0A, stat & 8'h0B)
    `CHK("stop lines", 2'b11, {scl, sda})
    wb(1'b0, ADR_CTRL, 8'h00); `CHK("stop enable", 1'b0, q[C_STOPEN])
    wb(1'b1, ADR_STAT, 8'h38);
    st();
    grab <= 1'b1;
    wb(1'b1, ADR_SHIFT, 8'hFF);
    wait_flag(8'h20); `CHK("tx collision", 8'h20, stat & 8'h21)
    grab <= 1'b0;
    repeat (4) @(posedge SYS_CLK);
    `CHK("lines free", 2'b11, {scl, sda})
    wb(1'b0, ADR_STAT, 8'h00); `CHK("stop after collision", 1'b1, q[S_IRQ])
    wb(1'b1, ADR_STAT, 8'h38);
    st();
    tx(8'($random(seed)));
    wb(1'b1, ADR_CTRL, 8'h29);
    wait_flag(8'h10);
    wb(1'b1, ADR_STAT, 8'h38);
    grab <= 1'b1;
    repeat (3) @(posedge SYS_CLK);
    wb(1'b1, ADR_CTRL, 8'h31);
    wait_flag(8'h20);
    wb(1'b0, ADR_CTRL, 8'h00); `CHK("start enable", 1'b0, q[C_STRTEN])
    grab <= 1'b0;
    repeat (4) @(posedge SYS_CLK);
    wb(1'b1, ADR_STAT, 8'h38);
    sleep <= 1'b1;
    foreign <= 1'b1;
    wait_flag(8'h10);
    repeat (2) @(posedge SYS_CLK);
    `CHK("wake", 1'b1, wake)
    foreign <= 1'b0;
    wb(1'b1, ADR_STAT, 8'h38);
    repeat (2) @(posedge SYS_CLK);
    `CHK("wake clear", 1'b0, wake)
    sleep <= 1'b0;
    wb(1'b1, ADR_CTRL, 8'h00);
    wb(1'b0, ADR_STAT, 8'h00); `CHK("detect bits", 8'h00, q[7:0] & 8'h06)
    wb(1'b1, ADR_CTRL, 8'h21);
    st();
    wb(1'b1, ADR_SHIFT, 8'hC3);
    repeat (10) @(posedge SYS_CLK);
    RST_N <= 1'b0;
    @(posedge SYS_CLK);
    `CHK("reset lines", 2'b00, {scl_oe, sda_oe})
    RST_N <= 1'b1;
    wb(1'b0, ADR_CTRL, 8'h00); `CHK("reset ctrl", 8'h00, q[7:0])
    close_out();
  end
endmodule : testbench
`default_nettype wire

// *** src/i2cm_core.sv ***
// I2C master ack, stop, start and arbitration sequencer with Wishbone slave
//
// Contract
// RULE1: Ack enable drives clock low and puts stored ack data on data line.
// RULE2: Software chooses ack data value before starting an ack sequence.
// RULE3: Ack: one period low, release clock, wait high, one period, clock low.
// RULE4: After ack clock low, clear ack enable, stop counter, go idle.
// RULE5: Shift buffer write during ack sequence sets write collision, buffer kept.
// RULE6: Stop: drive data low; once sampled low reload counter and count down.
// RULE7: Stop counter expiry releases clock; one period later data released.
// RULE8: Data high while clock high during stop sets stop-detected bit.
// RULE9: One period after stop-detected, clear stop enable, set port irq flag.
// RULE10: Shift buffer write during stop sequence sets write collision, buffer kept.
// RULE11: While sleeping, completed events wake processor if interrupt enabled.
// RULE12: Reset disables the port and aborts any transfer.
// RULE13: Start and stop detected bits clear on reset and when disabled.
// RULE14: Software takes bus only after stop detected or bus idle.
// RULE15: Bus stop seen while enabled raises the port irq flag.
// RULE16: Released one sampled zero sets bus collision flag, port goes idle.
// RULE17: Transmit collision halts, clears buffer full, releases lines.
// RULE18: Collision in a sequence aborts it, releases lines, clears its enable. The stop sequence here has no collision check.
// RULE19: After collision, keep watching bus; stop condition sets irq flag.
// RULE20: Next buffer write after collision sends from first data bit.
// RULE21: Either line low at start begin aborts start, flags collision.
// RULE22: Clock low while data high during start count flags collision.
// RULE23: Early data low restarts count; else data low at expiry, then clock low.
// RULE24: Rate counter reload value comes from the rate reload register.
//
// Design decisions made here: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module i2cm_core
  import i2cm_pkg::*;
(
  input  wire logic        SYS_CLK,
  input  wire logic        RST_N,
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [3:0]  WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output var  logic [31:0] WB_DAT_O,
  output var  logic        WB_ACK_O,
  input  wire logic        SCL_I,
  output var  logic        SCL_O,
  output var  logic        SCL_OE,
  input  wire logic        SDA_I,
  output var  logic        SDA_O,
  output var  logic        SDA_OE,
  input  wire logic        SLEEP_I,
  output var  logic        WAKE_O
);

  // ----------------------------------------------------------------------
  // State record
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic        scl_m;
    logic        scl_s;
    logic        scl_p;
    logic        sda_m;
    logic        sda_s;
    logic        sda_p;
    i2cm_state_t state;
    logic [7:0]  cnt;
    logic [7:0]  rate;
    logic [7:0]  shreg;
    logic [3:0]  bitn;
    logic        en;
    logic        ack_data_value;
    logic        ack_sequence_enable;
    logic        stopen;
    logic        starten;
    logic        irqen;
    logic        bf;
    logic        stopdet;
    logic        startdet;
    logic        write_collision_flag;
    logic        irqf;
    logic        bcl;
    logic        ackstat;
    logic        scl_drv;
    logic        sda_drv;
    logic        pin_lvl;
    logic        wake;
    logic        wb_ack;
    logic [31:0] wb_dat;
  } i2cm_regs_t;

  localparam i2cm_regs_t REGS_RESET = '{
    scl_m: 1'b1, scl_s: 1'b1, scl_p: 1'b1, sda_m: 1'b1, sda_s: 1'b1, sda_p: 1'b1,
    state: ST_IDLE, cnt: CNT_ZERO, rate: RATE_RESET, shreg: 8'h00, bitn: BIT_FIRST,
    en: 1'b0, ack_data_value: 1'b0, ack_sequence_enable: 1'b0, stopen: 1'b0, starten: 1'b0, irqen: 1'b0,
    bf: 1'b0, stopdet: 1'b0, startdet: 1'b0, write_collision_flag: 1'b0, irqf: 1'b0, bcl: 1'b0,
    ackstat: 1'b0, scl_drv: 1'b0, sda_drv: 1'b0, pin_lvl: 1'b0, wake: 1'b0,
    wb_ack: 1'b0, wb_dat: RD_ZERO
  };

  i2cm_regs_t r_reg;
  i2cm_regs_t r_next;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // A released one read back as zero means another master won
  function automatic logic arb_lost(input logic want_one, input logic sda_seen);
    arb_lost = want_one & ~sda_seen;
  endfunction : arb_lost

  // Status word as software sees it
  function automatic logic [31:0] stat_word(input i2cm_regs_t s);
    logic [31:0] w;
    w = RD_ZERO;
    w[S_BF]      = s.bf;
    w[S_STOPDET] = s.stopdet;
    w[S_STRTDET] = s.startdet;
    w[S_WRITE_COLLISION_FLAG]    = s.write_collision_flag;
    w[S_IRQ]     = s.irqf;
    w[S_BCL]     = s.bcl;
    w[S_ACKSTAT] = s.ackstat;
    w[S_BUSY]    = (s.state != ST_IDLE);
    stat_word = w;
  endfunction : stat_word

  // ----------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------
  always_comb begin
    logic tick;
    logic req;
    logic wr;
    logic wr_buf;
    logic seq_free;
    logic stop_ev;
    logic start_ev;
    logic collide;
    tick     = 1'b0;
    req      = 1'b0;
    wr       = 1'b0;
    wr_buf   = 1'b0;
    seq_free = 1'b0;
    stop_ev  = 1'b0;
    start_ev = 1'b0;
    collide  = 1'b0;
    r_next   = r_reg;

    // Two-flop synchronisers, then a third stage for edge finding
    r_next.scl_m = SCL_I;
    r_next.scl_s = r_reg.scl_m;
    r_next.scl_p = r_reg.scl_s;
    r_next.sda_m = SDA_I;
    r_next.sda_s = r_reg.sda_m;
    r_next.sda_p = r_reg.sda_s;
    stop_ev  = r_reg.scl_s & r_reg.scl_p & r_reg.sda_s & ~r_reg.sda_p;
    start_ev = r_reg.scl_s & r_reg.scl_p & ~r_reg.sda_s & r_reg.sda_p;

    // Rate counter runs down only while a sequence is active
    tick = (r_reg.cnt == CNT_ZERO);
    if (r_reg.state != ST_IDLE && !tick) begin
      r_next.cnt = r_reg.cnt - CNT_ONE;
    end

    // Wishbone slave: one wait state, every address answered
    req      = WB_CYC_I & WB_STB_I & ~r_reg.wb_ack;
    wr       = req & WB_WE_I & WB_SEL_I[0];
    wr_buf   = wr & (WB_ADR_I == ADR_SHIFT);
    seq_free = (r_reg.state == ST_IDLE) & r_reg.en
             & ~r_reg.ack_sequence_enable & ~r_reg.stopen & ~r_reg.starten;
    r_next.wb_ack = req;
    r_next.wb_dat = RD_ZERO;
    if (req && !WB_WE_I) begin
      unique case (WB_ADR_I)
        ADR_CTRL: begin
          r_next.wb_dat[C_EN]     = r_reg.en;
          r_next.wb_dat[C_ACK_DATA_VALUE]  = r_reg.ack_data_value;
          r_next.wb_dat[C_ACK_SEQUENCE_ENABLE]  = r_reg.ack_sequence_enable;
          r_next.wb_dat[C_STOPEN] = r_reg.stopen;
          r_next.wb_dat[C_STRTEN] = r_reg.starten;
          r_next.wb_dat[C_IRQEN]  = r_reg.irqen;
        end
        ADR_STAT:  r_next.wb_dat = stat_word(r_reg);
        ADR_SHIFT: r_next.wb_dat[7:0] = r_reg.shreg;
        ADR_RATE:  r_next.wb_dat[7:0] = r_reg.rate;
        default:   r_next.wb_dat = RD_ZERO;
      endcase
    end

    // Register writes; flag clears come first so hardware sets win
    if (wr) begin
      unique case (WB_ADR_I)
        ADR_CTRL: begin
          r_next.en    = WB_DAT_I[C_EN];
          r_next.ack_data_value = WB_DAT_I[C_ACK_DATA_VALUE];
          r_next.irqen = WB_DAT_I[C_IRQEN];
          // A sequence enable is taken only with nothing else running
          if (seq_free) begin
            r_next.ack_sequence_enable   = WB_DAT_I[C_ACK_SEQUENCE_ENABLE];
            r_next.stopen  = WB_DAT_I[C_STOPEN];
            r_next.starten = WB_DAT_I[C_STRTEN];
          end
        end
        ADR_STAT: begin
          if (WB_DAT_I[S_WRITE_COLLISION_FLAG]) r_next.write_collision_flag = 1'b0;
          if (WB_DAT_I[S_IRQ])  r_next.irqf = 1'b0;
          if (WB_DAT_I[S_BCL])  r_next.bcl  = 1'b0;
        end
        ADR_RATE: r_next.rate = WB_DAT_I[7:0];
        default: ;
      endcase
    end

    // Buffer write refused while any sequence runs
    if (wr_buf && !seq_free) begin
      r_next.write_collision_flag = 1'b1; // RULE5 RULE10
    end

    // Bus monitor for start and stop conditions
    if (stop_ev) begin
      r_next.stopdet  = 1'b1;
      r_next.startdet = 1'b0;
    end
    if (start_ev) begin
      r_next.startdet = 1'b1;
      r_next.stopdet  = 1'b0;
    end

    // Sequencer
    unique case (r_reg.state)
      ST_IDLE: begin
        if (stop_ev && r_reg.en) begin
          r_next.irqf = 1'b1; // RULE15 RULE19
        end
        if (r_reg.starten) begin
          if (!r_reg.scl_s || !r_reg.sda_s) begin
            collide = 1'b1; // RULE21
          end else begin
            r_next.scl_drv = 1'b0;
            r_next.sda_drv = 1'b0;
            r_next.cnt     = r_reg.rate; // RULE24
            r_next.state   = ST_STRT_A;
          end
        end else if (r_reg.stopen) begin
          r_next.scl_drv = 1'b1;
          r_next.sda_drv = 1'b1; // RULE6
          r_next.state   = ST_SP_LOW;
        end else if (r_reg.ack_sequence_enable) begin
          r_next.scl_drv = 1'b1; // RULE1
          r_next.sda_drv = ~r_reg.ack_data_value; // RULE1
          r_next.cnt     = r_reg.rate;
          r_next.state   = ST_AK_LOW;
        end else if (wr_buf && seq_free) begin
          // Always from the first data bit
          r_next.shreg   = WB_DAT_I[7:0];
          r_next.bitn    = BIT_FIRST; // RULE20
          r_next.bf      = 1'b1;
          r_next.scl_drv = 1'b1;
          r_next.sda_drv = ~WB_DAT_I[7];
          r_next.cnt     = r_reg.rate;
          r_next.state   = ST_TX_LOW;
        end
      end
      ST_STRT_A: begin
        if (!r_reg.sda_s) begin
          r_next.cnt     = r_reg.rate; // RULE23
          r_next.sda_drv = 1'b1;
          r_next.state   = ST_STRT_B;
        end else if (!r_reg.scl_s) begin
          collide = 1'b1; // RULE22
        end else if (tick) begin
          r_next.sda_drv = 1'b1; // RULE23
          r_next.cnt     = r_reg.rate;
          r_next.state   = ST_STRT_B;
        end
      end
      ST_STRT_B: begin
        // Clock level ignored here
        if (tick) begin
          r_next.scl_drv = 1'b1; // RULE23
          r_next.starten = 1'b0;
          r_next.irqf    = 1'b1;
          r_next.state   = ST_IDLE;
        end
      end
      ST_TX_LOW: begin
        if (tick) begin
          r_next.scl_drv = 1'b0;
          r_next.state   = ST_TX_REL;
        end
      end
      ST_TX_REL: begin
        // Clock stretching by slaves holds us here
        if (r_reg.scl_s) begin
          r_next.cnt   = r_reg.rate;
          r_next.state = ST_TX_HI;
        end
      end
      ST_TX_HI: begin
        if (r_reg.bitn <= BIT_DLAST && arb_lost(r_reg.shreg[7], r_reg.sda_s)) begin
          collide = 1'b1; // RULE16 RULE17
        end else if (tick) begin
          r_next.scl_drv = 1'b1;
          if (r_reg.bitn == BIT_ACK) begin
            r_next.ackstat = r_reg.sda_s;
            r_next.irqf    = 1'b1;
            r_next.state   = ST_IDLE;
          end else begin
            r_next.shreg = {r_reg.shreg[6:0], 1'b0};
            r_next.bitn  = r_reg.bitn + BIT_STEP;
            r_next.cnt   = r_reg.rate;
            r_next.state = ST_TX_LOW;
            if (r_reg.bitn == BIT_DLAST) begin
              r_next.bf      = 1'b0;
              r_next.sda_drv = 1'b0;
            end else begin
              r_next.sda_drv = ~r_reg.shreg[6];
            end
          end
        end
      end
      ST_AK_LOW: begin
        if (tick) begin
          r_next.scl_drv = 1'b0; // RULE3
          r_next.state   = ST_AK_REL;
        end
      end
      ST_AK_REL: begin
        if (r_reg.scl_s) begin
          r_next.cnt   = r_reg.rate; // RULE3
          r_next.state = ST_AK_HI;
        end
      end
      ST_AK_HI: begin
        if (arb_lost(r_reg.ack_data_value, r_reg.sda_s)) begin
          collide = 1'b1; // RULE18
        end else if (tick) begin
          r_next.scl_drv = 1'b1; // RULE3
          r_next.ack_sequence_enable   = 1'b0; // RULE4
          r_next.irqf    = 1'b1;
          r_next.state   = ST_IDLE; // RULE4
        end
      end
      ST_SP_LOW: begin
        if (!r_reg.sda_s) begin
          r_next.cnt   = r_reg.rate; // RULE6
          r_next.state = ST_SP_CNT;
        end
      end
      ST_SP_CNT: begin
        if (tick) begin
          r_next.scl_drv = 1'b0; // RULE7
          r_next.state   = ST_SP_SCL;
        end
      end
      ST_SP_SCL: begin
        if (r_reg.scl_s) begin
          r_next.cnt   = r_reg.rate;
          r_next.state = ST_SP_REL;
        end
      end
      ST_SP_REL: begin
        if (tick) begin
          r_next.sda_drv = 1'b0; // RULE7
          r_next.state   = ST_SP_WT;
        end
      end
      ST_SP_WT: begin
        if (r_reg.sda_s && r_reg.scl_s) begin
          r_next.stopdet  = 1'b1; // RULE8
          r_next.startdet = 1'b0;
          r_next.cnt      = r_reg.rate;
          r_next.state    = ST_SP_END;
        end
      end
      ST_SP_END: begin
        if (tick) begin
          r_next.stopen = 1'b0; // RULE9
          r_next.irqf   = 1'b1; // RULE9
          r_next.state  = ST_IDLE;
        end
      end
      default: r_next.state = ST_IDLE;
    endcase

    // Lost arbitration: drop everything and let go of both lines
    if (collide) begin
      r_next.bcl     = 1'b1; // RULE16 RULE21
      r_next.bf      = 1'b0; // RULE17
      r_next.scl_drv = 1'b0; // RULE17 RULE18
      r_next.sda_drv = 1'b0;
      r_next.ack_sequence_enable   = 1'b0; // RULE18
      r_next.stopen  = 1'b0;
      r_next.starten = 1'b0;
      r_next.state   = ST_IDLE;
    end

    // Disabled port: no transfer, no detect bits
    if (!r_reg.en) begin
      r_next.state    = ST_IDLE; // RULE12
      r_next.scl_drv  = 1'b0;
      r_next.sda_drv  = 1'b0;
      r_next.ack_sequence_enable    = 1'b0;
      r_next.stopen   = 1'b0;
      r_next.starten  = 1'b0;
      r_next.bf       = 1'b0;
      r_next.stopdet  = 1'b0; // RULE13
      r_next.startdet = 1'b0; // RULE13
    end

    // Wake request for a sleeping processor
    r_next.wake = SLEEP_I & r_reg.irqen & r_reg.irqf; // RULE11
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      r_reg <= REGS_RESET; // RULE12 RULE13
    end else begin
      r_reg <= r_next;
    end
  end

  // Outputs straight from the record
  assign WB_DAT_O = r_reg.wb_dat;
  assign WB_ACK_O = r_reg.wb_ack;
  assign SCL_O    = r_reg.pin_lvl;
  assign SCL_OE   = r_reg.scl_drv;
  assign SDA_O    = r_reg.pin_lvl;
  assign SDA_OE   = r_reg.sda_drv;
  assign WAKE_O   = r_reg.wake;

endmodule : i2cm_core

`default_nettype wire

// *** src/i2cm_pkg.sv ***
// Constants, register map and state encoding of the I2C master tail block
package i2cm_pkg;

  // ----------------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------------
  localparam logic [3:0] ADR_CTRL  = 4'h0;
  localparam logic [3:0] ADR_STAT  = 4'h4;
  localparam logic [3:0] ADR_SHIFT = 4'h8;
  localparam logic [3:0] ADR_RATE  = 4'hC;

  // ----------------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------------
  localparam int C_EN     = 0;
  localparam int C_ACK_DATA_VALUE  = 1;
  localparam int C_ACK_SEQUENCE_ENABLE  = 2;
  localparam int C_STOPEN = 3;
  localparam int C_STRTEN = 4;
  localparam int C_IRQEN  = 5;

  // ----------------------------------------------------------------------
  // Status register fields
  // ----------------------------------------------------------------------
  localparam int S_BF      = 0;
  localparam int S_STOPDET = 1;
  localparam int S_STRTDET = 2;
  localparam int S_WRITE_COLLISION_FLAG    = 3;
  localparam int S_IRQ     = 4;
  localparam int S_BCL     = 5;
  localparam int S_ACKSTAT = 6;
  localparam int S_BUSY    = 7;

  // ----------------------------------------------------------------------
  // Reset values, counts and widths
  // ----------------------------------------------------------------------
  localparam logic [7:0]  RATE_RESET = 8'h04;
  localparam logic [7:0]  CNT_ZERO   = 8'h00;
  localparam logic [7:0]  CNT_ONE    = 8'h01;
  localparam logic [3:0]  BIT_FIRST  = 4'h0;
  localparam logic [3:0]  BIT_DLAST  = 4'h7;
  localparam logic [3:0]  BIT_ACK    = 4'h8;
  localparam logic [3:0]  BIT_STEP   = 4'h1;
  localparam logic [31:0] RD_ZERO    = 32'h0000_0000;

  // ----------------------------------------------------------------------
  // Sequencer states, Gray codes in declaration order
  // ----------------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE   = 4'h0,
    ST_STRT_A = 4'h1,
    ST_STRT_B = 4'h3,
    ST_TX_LOW = 4'h2,
    ST_TX_REL = 4'h6,
    ST_TX_HI  = 4'h7,
    ST_AK_LOW = 4'h5,
    ST_AK_REL = 4'h4,
    ST_AK_HI  = 4'hC,
    ST_SP_LOW = 4'hD,
    ST_SP_CNT = 4'hF,
    ST_SP_SCL = 4'hE,
    ST_SP_REL = 4'hA,
    ST_SP_WT  = 4'hB,
    ST_SP_END = 4'h9
  } i2cm_state_t;

endpackage : i2cm_pkg
